// *** src/seq_pkg.sv ***
// Purpose: shared constants and types of the segment waveform sequencer
// Assumes: 250 MHz system clock, 32-bit register bus with byte addresses
// Notes:   angles are in tenths of a degree, phase is a 24-bit turn fraction
package seq_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_DIV      = 2500;
  localparam int TICK_US       = CLK_PERIOD_NS * TICK_DIV / 1000;
  localparam int LS_MIN_US     = 5000;
  localparam int LS_MAX_US     = 5000000;
  localparam int PH_W          = 24;
  // level/slope step bounds: shortest period rounds down, longest rounds up
  localparam int STEP_LS_MAX   = (1 << PH_W) / (LS_MIN_US / TICK_US);
  localparam int STEP_LS_MIN   = ((1 << PH_W) + LS_MAX_US / TICK_US - 1) / (LS_MAX_US / TICK_US);
  localparam int ANG_FULL      = 3600;
  localparam int ANG_SCALE     = (1 << PH_W) / ANG_FULL;
  localparam int COUNT_MAX     = 999;
  localparam int NSLOT         = 16;
  localparam int NAME_CHARS    = 10;

  localparam logic [5:0] A_CTRL   = 6'h00;
  localparam logic [5:0] A_SLOT   = 6'h04;
  localparam logic [5:0] A_SEGSEL = 6'h08;
  localparam logic [5:0] A_NAME0  = 6'h0c;
  localparam logic [5:0] A_NAME1  = 6'h10;
  localparam logic [5:0] A_NAME2  = 6'h14;
  localparam logic [5:0] A_MODE   = 6'h18;
  localparam logic [5:0] A_COUNT  = 6'h1c;
  localparam logic [5:0] A_PROT   = 6'h20;
  localparam logic [5:0] A_SEGCTL = 6'h24;
  localparam logic [5:0] A_STEP   = 6'h28;
  localparam logic [5:0] A_AMPOFF = 6'h2c;
  localparam logic [5:0] A_ANGLE  = 6'h30;
  localparam logic [5:0] A_LIMIT  = 6'h34;
  localparam logic [5:0] A_STATUS = 6'h38;
  localparam logic [5:0] A_NSEG   = 6'h3c;

  localparam int CTRL_RUN    = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_CREATE = 2;
  localparam int CTRL_INSERT = 3;
  localparam int SC_INI      = 3;

  localparam logic [15:0] RST_LIM_MAX = 16'h7fff;
  localparam logic [15:0] RST_LIM_MIN = 16'h8000;

  typedef enum logic [2:0] {
    SEG_SQUARE, SEG_RAMP_UP, SEG_RAMP_DN, SEG_TRIANGLE, SEG_SINE, SEG_LEVEL, SEG_TRIGGER, SEG_SLOPE
  } seg_type_t;

  typedef enum logic [1:0] {TRIG_HIGH, TRIG_LOW, TRIG_FALL} trig_cond_t;

endpackage : seq_pkg

// *** src/segment_waveform_sequencer.sv ***
// Purpose: segmented waveform sequencer driving a bipolar output setpoint
// Assumes: Avalon-MM slave, one wait cycle per access, trigger pin asynchronous
// Notes:   sine is a parabolic approximation; slope is linear interpolation
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module segment_waveform_sequencer
  import seq_pkg::*;
#(
  parameter int MAX_SEG   = 8,
  parameter int MEM_WORDS = 8388608
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic        trig_i,
  output logic      [15:0] setpoint_o,
  output logic             mode_o,
  output logic      [15:0] prot_pos_o,
  output logic      [15:0] prot_neg_o,
  output logic             running_o,
  output logic             trig_wait_o
);

  localparam int NS = NSLOT * MAX_SEG;
  localparam int SW = $clog2(NS);
  localparam int GW = $clog2(MAX_SEG);
  localparam logic [25:0] PH_TURN = 26'h100_0000;

  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_PLAY, S_TRIG, S_NEXT} seq_state_t;

  seg_type_t   s_typ  [NS];
  logic        s_ini  [NS];
  logic [1:0]  s_tc   [NS];
  logic [23:0] s_stp  [NS];
  logic [15:0] s_amp  [NS];
  logic [15:0] s_off  [NS];
  logic [11:0] s_sa   [NS];
  logic [11:0] s_so   [NS];
  logic        w_ok   [NSLOT];
  logic        w_mode [NSLOT];
  logic [9:0]  w_cnt  [NSLOT];
  logic [15:0] w_pp   [NSLOT];
  logic [15:0] w_pn   [NSLOT];
  logic [79:0] w_name [NSLOT];
  logic [GW:0] w_nseg [NSLOT];

  logic [79:0]        name_st;
  logic               mode_st;
  logic [3:0]         sl;
  logic [GW-1:0]      sg;
  logic signed [15:0] lim_max;
  logic signed [15:0] lim_min;

  seq_state_t         st;
  logic [3:0]         rsl;
  logic [GW-1:0]      rsg;
  logic [9:0]         ccnt;
  logic               first;
  logic [25:0]        acc;
  logic [25:0]        pend;
  logic signed [15:0] sfrom;
  logic [11:0]        tdiv;
  logic               tick;
  logic [2:0]         tsync;
  logic               tlev;
  logic               tprev;

  logic [5:0]          a;
  logic                wr_go;
  logic [31:0]         bm;
  logic [31:0]         wd;
  logic [31:0]         cw;
  logic [31:0]         rmux;
  logic [SW-1:0]       si;
  logic [SW-1:0]       ci;
  logic [MAX_SEG-1:0]  merr;
  logic                last;
  logic [25:0]         ld_start;
  logic [25:0]         ld_end;
  logic [25:0]         nacc;
  logic                trig_ok;
  logic signed [16:0]  wv;
  logic signed [33:0]  prod;
  logic signed [16:0]  dif;
  logic signed [33:0]  sprod;
  logic signed [18:0]  val;
  logic signed [15:0]  next_setpoint;

  function automatic logic [SW-1:0] sidx(logic [3:0] s, logic [GW-1:0] g);
    return SW'(int'(s) * MAX_SEG + int'(g));
  endfunction : sidx

  function automatic logic [25:0] ang_ph(logic [11:0] ang);
    return 26'(ang) * 26'(ANG_SCALE);
  endfunction : ang_ph

  // memory use grows as the segment frequency falls
  function automatic logic [31:0] mem_cost(logic [23:0] stp);
    logic [31:0] c;
    c = 32'h0100_0000;
    for (int i = 0; i < PH_W; i++) begin
      if (stp[i]) c = 32'h0100_0000 >> i;
    end
    return c;
  endfunction : mem_cost

  function automatic logic signed [16:0] wave(seg_type_t t, logic [23:0] p);
    logic [14:0]        f;
    logic [29:0]        q;
    logic signed [16:0] y;
    logic signed [16:0] r;
    f = p[22:8];
    q = {15'h0000, f} * {15'h0000, 15'h7fff - f};
    y = {1'b0, q[28:13]};
    case (t)
      SEG_SQUARE:   r = p[23] ? -17'sh08000 : 17'sh08000;
      SEG_RAMP_UP:  r = $signed({1'b0, p[23:8]}) - 17'sh08000;
      SEG_RAMP_DN:  r = 17'sh08000 - $signed({1'b0, p[23:8]});
      SEG_TRIANGLE: begin
        case (p[23:22])
          2'h0:    r = $signed({2'h0, p[21:7]});
          2'h1:    r = 17'sh07fff - $signed({2'h0, p[21:7]});
          2'h2:    r = -$signed({2'h0, p[21:7]});
          default: r = $signed({2'h0, p[21:7]}) - 17'sh07fff;
        endcase
      end
      SEG_SINE:     r = p[23] ? -y : y;
      default:      r = 17'sh00000;
    endcase
    return r;
  endfunction : wave

  // register bus
  assign a     = {address_i[5:2], 2'h0};
  assign wr_go = write_i & ~waitrequest_o;
  assign bm    = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}}, {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
  assign wd    = (rmux & ~bm) | (writedata_i & bm);
  assign cw    = (wr_go && a == A_CTRL) ? (writedata_i & bm) : 32'h0000_0000;
  assign si    = sidx(sl, sg);
  assign ci    = sidx(rsl, rsg);

  always_comb begin
    case (a)
      A_CTRL:   rmux = {30'h0000_0000, trig_wait_o, running_o};
      A_SLOT:   rmux = {27'h000_0000, {1'b0, sl} + 5'h01};
      A_SEGSEL: rmux = 32'(sg);
      A_NAME0:  rmux = w_name[sl][31:0];
      A_NAME1:  rmux = w_name[sl][63:32];
      A_NAME2:  rmux = {16'h0000, w_name[sl][79:64]};
      A_MODE:   rmux = {30'h0000_0000, w_ok[sl], w_mode[sl]};
      A_COUNT:  rmux = {22'h00_0000, w_cnt[sl]};
      A_PROT:   rmux = {w_pn[sl], w_pp[sl]};
      A_SEGCTL: rmux = {26'h000_0000, s_tc[si], s_ini[si], s_typ[si]};
      A_STEP:   rmux = {8'h00, s_stp[si]};
      A_AMPOFF: rmux = {s_off[si], s_amp[si]};
      A_ANGLE:  rmux = {4'h0, s_so[si], 4'h0, s_sa[si]};
      A_LIMIT:  rmux = {lim_min, lim_max};
      A_STATUS: rmux = {running_o, 5'h00, ccnt, 16'(merr)};
      A_NSEG:   rmux = 32'(w_nseg[sl]);
      default:  rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      waitrequest_o <= 1'b1;
      readdata_o    <= 32'h0000_0000;
    end else begin
      waitrequest_o <= ~((read_i | write_i) & waitrequest_o);
      if (read_i & waitrequest_o) readdata_o <= rmux;
    end
  end

  always_comb begin
    logic [31:0] used;
    used = 32'h0000_0000;
    merr = '0;
    for (int g = 0; g < MAX_SEG; g++) begin
      if (g < int'(w_nseg[sl])) begin
        used    = used + mem_cost(s_stp[sidx(sl, GW'(g))]);
        merr[g] = used > 32'(MEM_WORDS);
      end
    end
  end

  // waveform and segment storage
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NS; i++) begin
        s_typ[i] <= SEG_SINE;
        s_ini[i] <= 1'b0;
        s_tc[i]  <= 2'h0;
        s_stp[i] <= 24'h000100;
        s_amp[i] <= 16'h0000;
        s_off[i] <= 16'h0000;
        s_sa[i]  <= 12'h000;
        s_so[i]  <= 12'h000;
      end
      for (int i = 0; i < NSLOT; i++) begin
        w_ok[i]   <= 1'b0;
        w_mode[i] <= 1'b0;
        w_cnt[i]  <= 10'h000;
        w_pp[i]   <= 16'h0000;
        w_pn[i]   <= 16'h0000;
        w_name[i] <= 80'h0;
        w_nseg[i] <= '0;
      end
      name_st <= 80'h0;
      mode_st <= 1'b0;
      sl      <= 4'h0;
      sg      <= '0;
      lim_max <= RST_LIM_MAX;
      lim_min <= RST_LIM_MIN;
    end else if (wr_go) begin
      case (a)
        A_SLOT:   if (wd[4:0] != 5'h00 && wd[4:0] <= 5'(NSLOT)) sl <= 4'(wd[4:0] - 5'h01);
        A_SEGSEL: if (wd < 32'(MAX_SEG)) sg <= wd[GW-1:0];
        A_NAME0:  name_st[31:0]  <= writedata_i;
        A_NAME1:  name_st[63:32] <= writedata_i;
        A_NAME2:  name_st[79:64] <= writedata_i[15:0];
        A_MODE:   mode_st <= writedata_i[0];
        A_COUNT:  if (wd <= 32'(COUNT_MAX)) w_cnt[sl] <= wd[9:0];
        A_PROT:   begin
          w_pp[sl] <= wd[15:0];
          w_pn[sl] <= wd[31:16];
        end
        A_SEGCTL: begin
          s_typ[si] <= seg_type_t'(wd[2:0]);
          s_ini[si] <= wd[SC_INI];
          s_tc[si]  <= wd[5:4];
        end
        A_STEP: begin
          if (wd[23:0] != 24'h000000 &&
              (!(s_typ[si] inside {SEG_LEVEL, SEG_SLOPE}) ||
               (wd[23:0] >= 24'(STEP_LS_MIN) && wd[23:0] <= 24'(STEP_LS_MAX))))
            s_stp[si] <= wd[23:0];
        end
        A_AMPOFF: begin
          s_amp[si] <= wd[15:0];
          s_off[si] <= wd[31:16];
        end
        A_ANGLE: begin
          if (wd[11:0] <= 12'(ANG_FULL)) s_sa[si] <= wd[11:0];
          if (wd[27:16] <= 12'(ANG_FULL)) s_so[si] <= wd[27:16];
        end
        A_LIMIT: begin
          lim_max <= wd[15:0];
          lim_min <= wd[31:16];
        end
        A_CTRL: begin
          // create only into an empty slot and only with a name; mode is fixed here
          if (cw[CTRL_CREATE] && !w_ok[sl] && name_st[7:0] != 8'h00) begin
            w_ok[sl]             <= 1'b1;
            w_mode[sl]           <= mode_st;
            w_name[sl]           <= name_st;
            w_nseg[sl]           <= (GW+1)'(1);
            s_ini[sidx(sl, '0)]  <= 1'b0;
            s_sa[sidx(sl, '0)]   <= 12'h000;
            s_so[sidx(sl, '0)]   <= 12'h000;
          end
          // insert at the selected position, copying the highlighted segment, or the last one with s_ini cleared when appending
          if (cw[CTRL_INSERT] && w_ok[sl] && int'(w_nseg[sl]) < MAX_SEG &&
              {1'b0, sg} <= w_nseg[sl] && w_nseg[sl] != '0) begin
            for (int g = MAX_SEG - 1; g > 0; g--) begin
              if (g > int'(sg) && g <= int'(w_nseg[sl])) begin
                s_typ[sidx(sl, GW'(g))] <= s_typ[sidx(sl, GW'(g - 1))];
                s_ini[sidx(sl, GW'(g))] <= s_ini[sidx(sl, GW'(g - 1))];
                s_tc[sidx(sl, GW'(g))]  <= s_tc[sidx(sl, GW'(g - 1))];
                s_stp[sidx(sl, GW'(g))] <= s_stp[sidx(sl, GW'(g - 1))];
                s_amp[sidx(sl, GW'(g))] <= s_amp[sidx(sl, GW'(g - 1))];
                s_off[sidx(sl, GW'(g))] <= s_off[sidx(sl, GW'(g - 1))];
                s_sa[sidx(sl, GW'(g))]  <= s_sa[sidx(sl, GW'(g - 1))];
                s_so[sidx(sl, GW'(g))]  <= s_so[sidx(sl, GW'(g - 1))];
              end
            end
            if ({1'b0, sg} == w_nseg[sl]) begin
              s_typ[si] <= s_typ[si - SW'(1)];
              s_tc[si]  <= s_tc[si - SW'(1)];
              s_stp[si] <= s_stp[si - SW'(1)];
              s_amp[si] <= s_amp[si - SW'(1)];
              s_off[si] <= s_off[si - SW'(1)];
              s_sa[si]  <= s_sa[si - SW'(1)];
              s_so[si]  <= s_so[si - SW'(1)];
              s_ini[si] <= 1'b0;
            end
            w_nseg[sl] <= w_nseg[sl] + (GW+1)'(1);
          end
        end
        default: ;
      endcase
    end
  end

  // trigger pin synchroniser and level filter
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tsync <= 3'h0;
      tlev  <= 1'b0;
      tprev <= 1'b0;
    end else begin
      tsync <= {tsync[1:0], trig_i};
      if (tsync[1] == tsync[2]) tlev <= tsync[2];
      tprev <= tlev;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tdiv <= 12'h000;
      tick <= 1'b0;
    end else begin
      tick <= (tdiv == 12'(TICK_DIV - 1));
      tdiv <= (tdiv == 12'(TICK_DIV - 1)) ? 12'h000 : tdiv + 12'h001;
    end
  end

  always_comb begin
    last    = ({1'b0, rsg} + (GW+1)'(1)) == w_nseg[rsl] || int'(rsg) == MAX_SEG - 1;
    nacc    = acc + 26'(s_stp[ci]);
    ld_start = 26'h000_0000;
    ld_end   = PH_TURN;
    if (s_typ[ci] inside {SEG_SINE, SEG_TRIANGLE}) begin
      ld_start = ang_ph(s_sa[ci]);
      if (s_so[ci] != 12'h000 && s_so[ci] < 12'(ANG_FULL)) ld_end = ang_ph(s_so[ci]);
      if (ld_end <= ld_start) ld_end = ld_end + PH_TURN;
    end
    case (trig_cond_t'(s_tc[ci]))
      TRIG_HIGH: trig_ok = tlev;
      TRIG_LOW:  trig_ok = ~tlev;
      TRIG_FALL: trig_ok = tprev & ~tlev;
      default:   trig_ok = 1'b0;
    endcase
  end

  // segment sequencer
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st          <= S_IDLE;
      rsl         <= 4'h0;
      rsg         <= '0;
      ccnt        <= 10'h000;
      first       <= 1'b1;
      acc         <= 26'h000_0000;
      pend        <= PH_TURN;
      sfrom       <= 16'sh0000;
      mode_o      <= 1'b0;
      prot_pos_o  <= 16'h0000;
      prot_neg_o  <= 16'h0000;
      running_o   <= 1'b0;
      trig_wait_o <= 1'b0;
    end else begin
      case (st)
        S_IDLE: begin
          if (cw[CTRL_RUN] && w_ok[sl]) begin
            rsl        <= sl;
            rsg        <= '0;
            ccnt       <= 10'h000;
            first      <= 1'b1;
            mode_o     <= w_mode[sl];
            prot_pos_o <= w_pp[sl];
            prot_neg_o <= w_pn[sl];
            st         <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (s_ini[ci] && !first && !last) begin
            rsg <= rsg + GW'(1);
          end else begin
            acc   <= ld_start;
            pend  <= ld_end;
            sfrom <= setpoint_o;
            st    <= (s_typ[ci] == SEG_TRIGGER) ? S_TRIG : S_PLAY;
          end
        end
        S_PLAY: begin
          if (tick) begin
            if (nacc >= pend) st <= S_NEXT;
            else acc <= nacc;
          end
        end
        S_TRIG: if (trig_ok) st <= S_NEXT;
        S_NEXT: begin
          if (last) begin
            ccnt  <= ccnt + 10'h001;
            first <= 1'b0;
            rsg   <= '0;
            st    <= (w_cnt[rsl] != 10'h000 && ccnt + 10'h001 == w_cnt[rsl]) ? S_IDLE : S_LOAD;
          end else begin
            rsg <= rsg + GW'(1);
            st  <= S_LOAD;
          end
        end
        default: st <= S_IDLE;
      endcase
      if (cw[CTRL_STOP]) st <= S_IDLE;
      running_o   <= (st != S_IDLE) && !cw[CTRL_STOP];
      trig_wait_o <= (st == S_TRIG) && !cw[CTRL_STOP];
    end
  end

  // output value, centred on offset (slope runs from the last setpoint to it) and clamped to limits
  always_comb begin
    wv    = wave(s_typ[ci], acc[23:0]);
    prod  = $signed({1'b0, s_amp[ci]}) * wv;
    dif   = $signed({s_off[ci][15], s_off[ci]}) - $signed({sfrom[15], sfrom});
    sprod = dif * $signed({1'b0, acc[23:8]});
    case (s_typ[ci])
      SEG_LEVEL: val = {{3{s_off[ci][15]}}, s_off[ci]};
      SEG_SLOPE: val = {{3{sfrom[15]}}, sfrom} + 19'(sprod >>> 16);
      default:   val = {{3{s_off[ci][15]}}, s_off[ci]} + 19'(prod >>> 16);
    endcase
    if (val > $signed({{3{lim_max[15]}}, lim_max})) next_setpoint = lim_max;
    else if (val < $signed({{3{lim_min[15]}}, lim_min})) next_setpoint = lim_min;
    else next_setpoint = val[15:0];
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) setpoint_o <= 16'h0000;
    else if (st == S_PLAY) setpoint_o <= next_setpoint;
  end

endmodule : segment_waveform_sequencer

// *** verification/trig_port_model.sv ***
// Purpose: trigger source at the sequencer's trigger pin
// Assumes: the bench sets the wanted level and a reply delay
// Notes:   delay 0 answers at the next edge
`timescale 1ns/1ps
module trig_port_model (
  input  wire logic       clk_sys_i,
  input  wire logic       level_i,
  input  wire logic [7:0] delay_i,
  output logic            trig_o
);
  logic [7:0] cnt = 8'h00;
  initial trig_o = 1'b0;
  always @(posedge clk_sys_i) begin
    if (level_i == trig_o) cnt <= 8'h00;
    else if (cnt >= delay_i) trig_o <= level_i;
    else cnt <= cnt + 8'h01;
  end
endmodule : trig_port_model

// *** verification/segment_waveform_sequencer_checker.sv ***
// Purpose: port assertions of the waveform sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every sequencer instance
`timescale 1ns/1ps
module seq_checker (
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic        waitrequest_o,
  input wire logic [31:0] readdata_o,
  input wire logic [15:0] setpoint_o,
  input wire logic        mode_o,
  input wire logic [15:0] prot_pos_o,
  input wire logic [15:0] prot_neg_o,
  input wire logic        running_o,
  input wire logic        trig_wait_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_req;
    (read_i || write_i) && waitrequest_o;
  endsequence
  sequence s_wait2;
    trig_wait_o ##1 trig_wait_o;
  endsequence
  sequence s_run2;
    running_o ##1 running_o;
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> !waitrequest_o)
    else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  AST_RD_HOLD: assert property (!(read_i && waitrequest_o) |=> $stable(readdata_o))
    else $error("read data changed without a read");
  AST_PROT_LOCK: assert property (s_run2 |-> $stable({prot_pos_o, prot_neg_o}))
    else $error("protection limits changed while running");
  AST_MODE_LOCK: assert property (s_run2 |-> $stable(mode_o))
    else $error("mode changed while running");
  AST_TRIG_RUN: assert property (s_wait2 |-> running_o)
    else $error("trigger wait while idle");
  AST_TRIG_HOLD: assert property (s_wait2 |-> $stable(setpoint_o))
    else $error("setpoint moved during trigger wait");
  AST_IDLE_HOLD: assert property (!running_o [*3] |-> $stable(setpoint_o))
    else $error("setpoint moved while idle");
endmodule : seq_checker

bind segment_waveform_sequencer seq_checker i_seq_checker (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .read_i(read_i), .write_i(write_i),
  .waitrequest_o(waitrequest_o), .readdata_o(readdata_o), .setpoint_o(setpoint_o), .mode_o(mode_o),
  .prot_pos_o(prot_pos_o), .prot_neg_o(prot_neg_o), .running_o(running_o), .trig_wait_o(trig_wait_o));

// *** verification/tb_segment_waveform_sequencer.sv ***
// Purpose: self-checking bench of the waveform sequencer
// Assumes: 250 MHz clock, bus master waits on waitrequest
// Notes:   zero-amplitude squares mark segments by offset
`timescale 1ns/1ps
module tb_segment_waveform_sequencer;
  import seq_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, lvl = 1'b0, wreq, run, twait, mode, trig;
  logic [5:0]  addr = 6'h00;
  logic [7:0]  dly = 8'h00;
  logic [15:0] sp, pp, pn, last = 16'h0000;
  logic [15:0] seen[$];
  logic [31:0] wdata = 32'h0, rdata;
  int          errors = 0, n_compared = 0, cyc = 0;
  always #2 clk = ~clk;
  segment_waveform_sequencer #(.MAX_SEG(8), .MEM_WORDS(5)) i_segment_waveform_sequencer (
    .clk_sys_i(clk), .resetn_i(rstn), .address_i(addr), .read_i(rd), .write_i(wr), .byteenable_i(4'hf),
    .writedata_i(wdata), .readdata_o(rdata), .waitrequest_o(wreq), .trig_i(trig), .setpoint_o(sp),
    .mode_o(mode), .prot_pos_o(pp), .prot_neg_o(pn), .running_o(run), .trig_wait_o(twait));
  trig_port_model i_trig_port_model (.clk_sys_i(clk), .level_i(lvl), .delay_i(dly), .trig_o(trig));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sp !== last) seen.push_back(sp);
    last <= sp;
    if (cyc == 90000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end
  task automatic finish_test;
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    // one idle edge so the next request never re-raises a strobe in the same step
    @(posedge clk);
  endtask : bus
  task automatic w32(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : w32
  task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rdc
  task automatic idle;
    repeat (4) @(posedge clk);
    while (run !== 1'b0) @(posedge clk);
  endtask : idle
  task automatic t_create;
    rdc(A_LIMIT, '1, 32'h8000_7fff);
    w32(A_SLOT, 32'h0);
    w32(A_SLOT, 32'h11);
    rdc(A_SLOT, '1, 32'h1);
    w32(A_NAME0, 32'h4443_4241);
    w32(A_NAME2, 32'h0000_4a49);
    w32(A_MODE, 32'h1);
    w32(A_CTRL, 32'h4);
    rdc(A_NAME0, '1, 32'h4443_4241);
    rdc(A_NAME2, 32'hffff, 32'h4a49);
    rdc(A_NSEG, '1, 32'h1);
    rdc(A_SEGCTL, 32'h8, 32'h0);
    w32(A_MODE, 32'h0);
    rdc(A_MODE, 32'h3, 32'h3);
    w32(A_ANGLE, 32'h0e10_0e10);
    w32(A_ANGLE, 32'h0e11_0e11);
    rdc(A_ANGLE, '1, 32'h0e10_0e10);
    w32(A_ANGLE, 32'h0);
    w32(A_COUNT, 32'h3e7);
    w32(A_COUNT, 32'h3e8);
    rdc(A_COUNT, '1, 32'h3e7);
  endtask : t_create
  task automatic t_sequence;
    logic [15:0] e[6] = '{16'h0008, 16'h0002, 16'h0700, 16'h0500, 16'h0700, 16'h0500};
    w32(A_COUNT, 32'd2);
    w32(A_SEGCTL, 32'h0);
    w32(A_STEP, 32'h80_0000);
    w32(A_AMPOFF, 32'h0002_0000);
    w32(A_SEGSEL, 32'h1);
    w32(A_CTRL, 32'h8);
    rdc(A_SEGCTL, 32'h8, 32'h0);
    w32(A_AMPOFF, 32'h0600_0200);
    w32(A_SEGCTL, 32'h8);
    w32(A_SEGSEL, 32'h0);
    w32(A_SEGCTL, 32'h8);
    w32(A_CTRL, 32'h8);
    rdc(A_SEGCTL, 32'h8, 32'h8);
    w32(A_AMPOFF, 32'h0008_0000);
    rdc(A_STATUS, 32'hffff, 32'h4);
    w32(A_PROT, 32'h1234_0567);
    seen = {};
    w32(A_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk({pn, pp}, 32'h1234_0567);
    chk({31'h0, mode}, 32'h1);
    chk({31'h0, run}, 32'h1);
    idle();
    chk(32'(seen.size()), 32'h6);
    for (int i = 0; i < 6; i++) chk({16'h0, seen[i]}, {16'h0, e[i]});
    rdc(A_STATUS, 32'h83ff_0000, 32'h2_0000);
  endtask : t_sequence
  task automatic t_clamp;
    w32(A_COUNT, 32'h0);
    w32(A_LIMIT, 32'h0004_06c0);
    seen = {};
    w32(A_CTRL, 32'h1);
    while (seen.size() < 6) @(posedge clk);
    chk({31'h0, run}, 32'h1);
    w32(A_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, run}, 32'h0);
    chk({16'h0, seen[0]}, 32'h0008);
    chk({16'h0, seen[1]}, 32'h0004);
    chk({16'h0, seen[2]}, 32'h06c0);
    chk({16'h0, seen[3]}, 32'h0500);
    chk({16'h0, seen[4]}, 32'h06c0);
    w32(A_LIMIT, 32'h8000_7fff);
  endtask : t_clamp
  task automatic t_trigger;
    logic bad;
    bad = 1'b0;
    w32(A_SLOT, 32'h2);
    w32(A_NAME0, 32'h5a);
    w32(A_CTRL, 32'h4);
    w32(A_COUNT, 32'h1);
    w32(A_STEP, 32'h80_0000);
    w32(A_AMPOFF, 32'h0055_0000); // offset kept nonzero so it must be ignored
    w32(A_SEGSEL, 32'h1);
    w32(A_CTRL, 32'h8);
    w32(A_SEGCTL, 32'h0);
    w32(A_AMPOFF, 32'h0011_0000);
    for (int c = 0; c < 3; c++) begin
      lvl <= (c != 0);
      dly <= 8'(c * 30);
      w32(A_SEGSEL, 32'h0);
      w32(A_SEGCTL, 32'h6 | 32'(c << 4));
      repeat (100) @(posedge clk);
      w32(A_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      chk({31'h0, twait}, 32'h1);
      chk({31'h0, mode}, 32'h0);
      lvl <= (c == 0);
      idle();
      chk({16'h0, sp}, 32'h0011);
    end
    foreach (seen[i]) if (seen[i] === 16'h0055) bad = 1'b1;
    chk({31'h0, bad}, 32'h0);
  endtask : t_trigger
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_create();
    t_sequence();
    t_clamp();
    t_trigger();
    finish_test();
  end
endmodule : tb_segment_waveform_sequencer
